// file: rtl/ssc_defs.svh
// constants shared by the serial sram command port ends
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
// opcodes
`define SSC_OP_WRITE 8'h02
`define SSC_OP_READ 8'h03
`define SSC_OP_MR_WR 8'h01
`define SSC_OP_MR_RD 8'h05
`define SSC_OP_DUAL 8'h3B
`define SSC_OP_QUAD 8'h38
`define SSC_OP_SINGLE 8'hFF
// access mode register values
`define SSC_MODE_BYTE 8'h00
`define SSC_MODE_SEQ 8'h40
`define SSC_MODE_PAGE 8'h80
`define SSC_MODE_RST `SSC_MODE_SEQ
// array geometry: 128k bytes, 32-byte pages, 3 address bytes
`define SSC_ADDR_W 17
`define SSC_PAGE_BITS 5
`define SSC_ADDR_BYTES 3
// host link timing
`define SSC_CLK_NS 50
`define SSC_SCK_HALF_NS 400
`define SSC_SCK_HALF_CYC (`SSC_SCK_HALF_NS / `SSC_CLK_NS)
// host register word indices and fields
`define SSC_REG_CTRL 2'h0
`define SSC_REG_DATA 2'h1
`define SSC_REG_STAT 2'h2
`define SSC_CTRL_CS 0
`define SSC_STAT_BUSY 0
`define SSC_STAT_CS 1
`define SSC_STAT_BOOT 2
`endif

// file: rtl/ssc_pkg.sv
// types shared by the serial sram command port ends
`include "ssc_defs.svh"
package ssc_pkg;
    typedef enum logic [2:0] {
        D_CMD = 3'b000,
        D_ADDR = 3'b001,
        D_RD = 3'b010,
        D_WR = 3'b011,
        D_MRW = 3'b100,
        D_SKIP = 3'b101
    } ssc_dev_st_t;
    typedef enum logic [1:0] {
        IO_SINGLE = 2'b00,
        IO_DUAL = 2'b01,
        IO_QUAD = 2'b10
    } ssc_io_t;
    typedef enum logic [1:0] {
        H_BOOT = 2'b00,
        H_IDLE = 2'b01,
        H_RUN = 2'b10
    } ssc_host_st_t;
endpackage

// file: rtl/ssc_if.sv
// spi link between host and serial sram
`timescale 1ns/100ps
interface ssc_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;
    // undriven data line reads high, as with a pull-up
    assign miso = miso_oe ? miso_o : 1'b1;
    modport dev (input sck, input cs_n, input mosi, output miso_o, output miso_oe);
    modport host (output sck, output cs_n, output mosi, input miso);
endinterface

// file: rtl/ssc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module ssc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssc_sync_t;
    ssc_sync_t r_q;
    ssc_sync_t r_d;

    if (W < 1)
    begin : g_chk
        $error("ssc_sync: width must be at least 1");
    end

    always_comb
    begin
        r_d = r_q;
        if (ce)
        begin
            r_d.s1 = d;
            r_d.s2 = r_q.s1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign q = r_q.s2;
endmodule

// file: rtl/ssc_sram_dev.sv
// serial sram device end: spi slave, command decoder and byte array
`timescale 1ns/100ps
`include "ssc_defs.svh"
module ssc_sram_dev #(
    parameter int ADDR_W = `SSC_ADDR_W
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // spi link
    ssc_if.dev lnk,
    // status
    output logic [7:0] access_mode_q,
    output ssc_pkg::ssc_io_t line_mode_q,
    output logic selected_q
);
    import ssc_pkg::*;

    localparam int MEM_BYTES = 1 << ADDR_W;

    typedef struct packed {
        ssc_dev_st_t st;
        logic is_rd;
        logic [1:0] abytes;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [ADDR_W-1:0] addr;
        logic [7:0] mode;
        ssc_io_t io;
        logic sck_d;
        logic miso;
        logic oe;
        logic sel;
        logic wr_en;
        logic [ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
    } ssc_dev_t;

    localparam ssc_dev_t RST = '{
        st: D_CMD,
        mode: `SSC_MODE_RST,
        io: IO_SINGLE,
        default: '0
    };

    ssc_dev_t q;
    ssc_dev_t d;
    logic [7:0] mem [MEM_BYTES];
    logic [2:0] pins;
    logic sck_s;
    logic cs_n_s;
    logic mosi_s;

    if (ADDR_W < 9 || ADDR_W > 8 * `SSC_ADDR_BYTES)
    begin : g_chk
        $error("ssc_sram_dev: ADDR_W must lie in 9..24");
    end

    ssc_sync #(.W(3)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        // select carried inverted so the flops' reset level reads as deselected
        .d({lnk.sck, !lnk.cs_n, lnk.mosi}),
        .q(pins)
    );
    assign sck_s = pins[2];
    assign cs_n_s = !pins[1];
    assign mosi_s = pins[0];

    // next address after an access, by access mode
    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a,
        input logic [7:0] mode
    );
        logic [ADDR_W-1:0] n;
        n = a + 1'b1;
        if (mode == `SSC_MODE_PAGE)
            n = {a[ADDR_W-1:`SSC_PAGE_BITS], n[`SSC_PAGE_BITS-1:0]};
        return n;
    endfunction

    function automatic logic mode_legal(input logic [7:0] v);
        return v == `SSC_MODE_BYTE || v == `SSC_MODE_SEQ || v == `SSC_MODE_PAGE;
    endfunction

    always_comb
    begin
        logic [7:0] by;
        logic [ADDR_W-1:0] a;
        by = {q.sh[6:0], mosi_s};
        a = {q.addr[ADDR_W-9:0], by};
        d = q;
        d.wr_en = 1'b0;
        d.sck_d = sck_s;
        d.sel = !cs_n_s;
        if (cs_n_s)
        begin
            // deselect aborts any command and floats the data line
            d.st = D_CMD;
            d.bitc = '0;
            d.tx = '0;
            // drop the prefetched byte, which may come from unwritten cells
            d.miso = 1'b0;
            d.oe = 1'b0;
        end
        else
        begin
            d.oe = 1'b1;
            if (!sck_s && q.sck_d)
            begin
                // output moves on the falling edge, sampled by the host at the end of the high phase
                d.miso = q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
            end
            if (sck_s && !q.sck_d)
            begin
                d.sh = by;
                d.bitc = q.bitc + 3'd1;
                if (q.bitc == 3'd7)
                begin
                    case (q.st)
                        D_CMD:
                        begin
                            d.st = D_SKIP;
                            if (q.io != IO_SINGLE)
                            begin
                                // multi-line framing is not decoded; only the
                                // single-line escape is looked for
                                if (by == `SSC_OP_SINGLE)
                                    d.io = IO_SINGLE;
                            end
                            else if (by == `SSC_OP_READ || by == `SSC_OP_WRITE)
                            begin
                                d.st = D_ADDR;
                                d.is_rd = by == `SSC_OP_READ;
                                d.abytes = '0;
                            end
                            else if (by == `SSC_OP_MR_WR)
                                d.st = D_MRW;
                            else if (by == `SSC_OP_MR_RD)
                                d.tx = q.mode;
                            else if (by == `SSC_OP_DUAL)
                                d.io = IO_DUAL;
                            else if (by == `SSC_OP_QUAD)
                                d.io = IO_QUAD;
                            else if (by == `SSC_OP_SINGLE)
                                d.io = IO_SINGLE;
                        end
                        D_ADDR:
                        begin
                            // big-endian; bits above the array fall off the top
                            d.addr = a;
                            d.abytes = q.abytes + 2'd1;
                            if (q.abytes == 2'(`SSC_ADDR_BYTES - 1))
                            begin
                                if (q.is_rd)
                                begin
                                    d.st = D_RD;
                                    d.tx = mem[a];
                                    d.addr = next_addr(a, q.mode);
                                end
                                else
                                    d.st = D_WR;
                            end
                        end
                        D_RD:
                        begin
                            if (q.mode == `SSC_MODE_BYTE)
                                d.st = D_SKIP;
                            else
                            begin
                                d.tx = mem[q.addr];
                                d.addr = next_addr(q.addr, q.mode);
                            end
                        end
                        D_WR:
                        begin
                            d.wr_en = 1'b1;
                            d.wr_addr = q.addr;
                            d.wr_data = by;
                            d.addr = next_addr(q.addr, q.mode);
                            if (q.mode == `SSC_MODE_BYTE)
                                d.st = D_SKIP;
                        end
                        D_MRW:
                        begin
                            // illegal values are dropped, keeping the old mode
                            if (mode_legal(by))
                                d.mode = by;
                            d.st = D_SKIP;
                        end
                        default:
                            d.st = D_SKIP;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q <= RST;
        else if (ce)
            q <= d;
    end

    // array has no reset: contents are undefined after power-up
    always_ff @(posedge clk)
    begin
        if (ce && q.wr_en)
            mem[q.wr_addr] <= q.wr_data;
    end

    assign lnk.miso_o = q.miso;
    assign lnk.miso_oe = q.oe;
    assign access_mode_q = q.mode;
    assign line_mode_q = q.io;
    assign selected_q = q.sel;
endmodule

// file: rtl/ssc_host.sv
// spi host end: avalon-mm controlled byte exchanger for the serial sram
`timescale 1ns/100ps
`include "ssc_defs.svh"
module ssc_host #(
    parameter int SCK_HALF = `SSC_SCK_HALF_CYC
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // spi link
    ssc_if.host lnk
);
    import ssc_pkg::*;

    typedef struct packed {
        ssc_host_st_t st;
        logic boot;
        logic cs_n;
        logic sck;
        logic mosi;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] bitc;
        logic [7:0] div;
        logic wait_r;
        logic [31:0] rdata;
    } ssc_host_r_t;

    localparam ssc_host_r_t RST = '{
        st: H_BOOT,
        boot: 1'b1,
        cs_n: 1'b1,
        wait_r: 1'b1,
        default: '0
    };

    ssc_host_r_t q;
    ssc_host_r_t d;
    logic miso_s;

    // the device answers through its own synchroniser; the sample point
    // at the end of the high phase needs about six cycles of margin
    if (SCK_HALF < 6 || SCK_HALF > 255)
    begin : g_chk
        $error("ssc_host: SCK_HALF must lie in 6..255");
    end

    ssc_sync #(.W(1)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(lnk.miso),
        .q(miso_s)
    );

    always_comb
    begin
        logic req;
        req = (avs_read || avs_write) && q.wait_r;
        d = q;
        d.wait_r = 1'b1;
        if (req && avs_read)
        begin
            d.wait_r = 1'b0;
            d.rdata = '0;
            if (avs_address == `SSC_REG_CTRL)
                d.rdata[`SSC_CTRL_CS] = !q.cs_n;
            else if (avs_address == `SSC_REG_DATA)
                d.rdata[7:0] = q.rx;
            else if (avs_address == `SSC_REG_STAT)
            begin
                d.rdata[`SSC_STAT_BUSY] = q.st != H_IDLE;
                d.rdata[`SSC_STAT_CS] = !q.cs_n;
                d.rdata[`SSC_STAT_BOOT] = q.boot;
            end
        end
        case (q.st)
            H_BOOT:
            begin
                // every session opens by forcing the single-line mode
                d.cs_n = 1'b0;
                d.tx = `SSC_OP_SINGLE;
                d.bitc = '0;
                d.div = '0;
                d.st = H_RUN;
            end
            H_IDLE:
            begin
                if (req && avs_write)
                begin
                    d.wait_r = 1'b0;
                    if (avs_address == `SSC_REG_CTRL)
                        d.cs_n = !avs_writedata[`SSC_CTRL_CS];
                    else if (avs_address == `SSC_REG_DATA && !q.cs_n)
                    begin
                        // one byte out is always one byte in
                        d.tx = avs_writedata[7:0];
                        d.bitc = '0;
                        d.div = '0;
                        d.st = H_RUN;
                    end
                end
            end
            H_RUN:
            begin
                // writes stall here, so frames never close mid-byte
                d.div = q.div + 8'd1;
                if (q.div == 8'(SCK_HALF - 1))
                begin
                    d.div = '0;
                    if (!q.sck)
                        d.sck = 1'b1;
                    else
                    begin
                        d.sck = 1'b0;
                        d.rx = {q.rx[6:0], miso_s};
                        if (q.bitc == 3'd7)
                        begin
                            d.st = H_IDLE;
                            if (q.boot)
                            begin
                                d.boot = 1'b0;
                                d.cs_n = 1'b1;
                            end
                        end
                        else
                        begin
                            d.bitc = q.bitc + 3'd1;
                            d.tx = {q.tx[6:0], 1'b0};
                        end
                    end
                end
            end
            default:
                d.st = H_IDLE;
        endcase
        d.mosi = d.tx[7];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q <= RST;
        else if (ce)
            q <= d;
    end

    assign lnk.sck = q.sck;
    assign lnk.cs_n = q.cs_n;
    assign lnk.mosi = q.mosi;
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wait_r;
endmodule

// file: bench/ssc_link_properties.sv
// link-level properties of the serial sram command port
`timescale 1ns/100ps
module ssc_link_properties (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // spi link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    logic sck_q;
    logic cs_q;
    logic boot_q;
    logic [2:0] bits_q;
    // rises of sck inside a frame, so a frame must close on a byte boundary
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            boot_q <= 1'b1;
            bits_q <= 3'h0;
        end
        else
        begin
            sck_q <= sck;
            cs_q <= cs_n;
            if (cs_n && !cs_q)
                boot_q <= 1'b0;
            if (cs_n)
                bits_q <= 3'h0;
            else if (sck && !sck_q)
                bits_q <= bits_q + 3'h1;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // half period fixed at the host default of 8 cycles
    sequence high_run;
        sck[*8] ##1 !sck;
    endsequence
    sequence low_run;
        !sck[*8];
    endsequence
    sck_high_time_a: assert property ($rose(sck) |-> high_run)
        else $error("sck high phase length wrong");
    sck_low_time_a: assert property ($fell(sck) |-> low_run)
        else $error("sck low phase too short");
    sck_idle_low_a: assert property (cs_n |-> !sck)
        else $error("sck not low outside frame");
    mosi_hold_a: assert property ($rose(sck) |-> $stable(mosi)[*8])
        else $error("mosi moved while sck high");
    miso_hold_a: assert property ($rose(sck) |-> $stable(miso_o)[*8])
        else $error("miso moved while sck high");
    whole_bytes_a: assert property ($rose(cs_n) |-> bits_q == 3'h0)
        else $error("frame closed mid byte");
    boot_ones_a: assert property (boot_q && $rose(sck) |-> mosi)
        else $error("session start byte not all ones");
    miso_drive_a: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
        else $error("device did not drive miso in frame");
    miso_release_a: assert property (cs_n[*6] |-> !miso_oe && miso)
        else $error("miso still driven after frame");
endmodule

// file: bench/testbench.sv
// self-checking bench: avalon host end driving the serial sram end
`timescale 1ns/100ps
`include "ssc_defs.svh"
module testbench;
    import ssc_pkg::*;
    typedef logic [7:0] ssc_bytes_t[$];
    logic clk;
    logic nrst;
    logic [1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] access_mode_q;
    ssc_io_t line_mode_q;
    logic selected_q;
    int n_errors;
    int check_count;
    logic [31:0] w;
    ssc_bytes_t rx;

    ssc_if lnk_if ();
    ssc_host ssc_host_inst (
        .clk(clk),
        .nrst(nrst),
        .ce(1'b1),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .lnk(lnk_if.host)
    );
    ssc_sram_dev ssc_sram_dev_inst (
        .clk(clk),
        .nrst(nrst),
        .ce(1'b1),
        .lnk(lnk_if.dev),
        .access_mode_q(access_mode_q),
        .line_mode_q(line_mode_q),
        .selected_q(selected_q)
    );
    ssc_link_properties ssc_link_properties_inst (
        .clk(clk),
        .nrst(nrst),
        .sck(lnk_if.sck),
        .cs_n(lnk_if.cs_n),
        .mosi(lnk_if.mosi),
        .miso_o(lnk_if.miso_o),
        .miso_oe(lnk_if.miso_oe),
        .miso(lnk_if.miso)
    );

    always #25 clk = ~clk;

    task automatic fail(input string msg);
        n_errors++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
            fail($sformatf("got %h expected %h", got, exp));
    endtask
    // one avalon access; result left in w; an edge passes before the next
    task automatic av(input logic [1:0] a, input logic wr, input logic [31:0] wd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        @(posedge clk);
        // no limit here: a hung bus is ended by the watchdog
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        w = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int idx);
        int n;
        n = 0;
        do
        begin
            av(`SSC_REG_STAT, 1'b0, 32'h0000_0000);
            n++;
        end
        while (w[idx] !== 1'b0 && n < 300);
        if (n == 300)
        begin
            fail("status bit stuck");
            final_report();
        end
    endtask
    // one cs frame: each byte sent is paired with one byte received
    task automatic frame(input ssc_bytes_t tx);
        rx = {};
        av(`SSC_REG_CTRL, 1'b1, 32'h0000_0001);
        foreach (tx[i])
        begin
            av(`SSC_REG_DATA, 1'b1, {24'h00_0000, tx[i]});
            poll(`SSC_STAT_BUSY);
            av(`SSC_REG_DATA, 1'b0, 32'h0000_0000);
            rx.push_back(w[7:0]);
        end
        check8({7'h00, selected_q}, 8'h01);
        av(`SSC_REG_CTRL, 1'b1, 32'h0000_0000);
        av(`SSC_REG_STAT, 1'b0, 32'h0000_0000);
        check8({7'h00, w[`SSC_STAT_CS]}, 8'h00);
    endtask
    task automatic mem(input logic [7:0] op, input logic [23:0] a, input ssc_bytes_t d);
        ssc_bytes_t tx;
        tx = {op, a[23:16], a[15:8], a[7:0]};
        foreach (d[i])
            tx.push_back(d[i]);
        frame(tx);
        rx = rx[4:$];
    endtask
    task automatic rd_check(input logic [23:0] a, input ssc_bytes_t exp);
        ssc_bytes_t z;
        foreach (exp[i])
            z.push_back(8'h00);
        mem(`SSC_OP_READ, a, z);
        foreach (exp[i])
            check8(rx[i], exp[i]);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        fail("watchdog expired");
        final_report();
    end

    initial
    begin
        logic [7:0] modes [4];
        logic [7:0] ops [2];
        clk = 1'b0;
        nrst = 1'b0;
        avs_address = 2'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        n_errors = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check8(access_mode_q, `SSC_MODE_RST);
        check8({6'h00, line_mode_q}, {6'h00, IO_SINGLE});
        poll(`SSC_STAT_BOOT);
        av(2'h3, 1'b0, 32'h0000_0000);
        check8({7'h00, |w}, 8'h00);
        // data write with cs released must not start a transfer
        av(`SSC_REG_DATA, 1'b1, 32'h0000_0055);
        av(`SSC_REG_STAT, 1'b0, 32'h0000_0000);
        check8(w[7:0], 8'h00);
        $display("test reset_boot done");
        mem(`SSC_OP_WRITE, 24'hFF_FFFE, {8'hA0, 8'hA1, 8'hA2});
        rd_check(24'h01_FFFE, {8'hA0, 8'hA1, 8'hA2});
        rd_check(24'h00_0000, {8'hA2});
        $display("test seq_wrap done");
        modes = '{`SSC_MODE_BYTE, `SSC_MODE_PAGE, `SSC_MODE_SEQ, 8'h20};
        foreach (modes[i])
        begin
            frame({`SSC_OP_MR_WR, modes[i]});
            frame({`SSC_OP_MR_RD, 8'h00});
            check8(rx[1], (i == 3) ? `SSC_MODE_SEQ : modes[i]);
            check8(access_mode_q, (i == 3) ? `SSC_MODE_SEQ : modes[i]);
        end
        $display("test mode_reg done");
        frame({`SSC_OP_MR_WR, `SSC_MODE_PAGE});
        mem(`SSC_OP_WRITE, 24'h00_003E, {8'hC0, 8'hC1, 8'hC2});
        rd_check(24'h00_003F, {8'hC1, 8'hC2});
        frame({`SSC_OP_MR_WR, `SSC_MODE_SEQ});
        rd_check(24'h00_0020, {8'hC2});
        $display("test page_wrap done");
        mem(`SSC_OP_WRITE, 24'h00_0100, {8'h11, 8'h22});
        frame({`SSC_OP_MR_WR, `SSC_MODE_BYTE});
        mem(`SSC_OP_WRITE, 24'h00_0100, {8'h33, 8'h44});
        rd_check(24'h00_0100, {8'h33, 8'h00});
        frame({`SSC_OP_MR_WR, `SSC_MODE_SEQ});
        rd_check(24'h00_0100, {8'h33, 8'h22});
        $display("test byte_mode done");
        ops = '{`SSC_OP_DUAL, `SSC_OP_QUAD};
        foreach (ops[i])
        begin
            frame({ops[i]});
            check8({6'h00, line_mode_q}, {6'h00, (i == 0) ? IO_DUAL : IO_QUAD});
            frame({`SSC_OP_MR_WR, `SSC_MODE_PAGE});
            check8(access_mode_q, `SSC_MODE_SEQ);
            frame({`SSC_OP_SINGLE});
            check8({6'h00, line_mode_q}, {6'h00, IO_SINGLE});
        end
        $display("test line_mode done");
        final_report();
    end
endmodule
